//--- rtl/prot_host.sv
module prot_host #(
  parameter int ADDR_W = 27,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic last;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cyc_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_GAP = 2'b01, M_ISSUE = 2'b11, M_WAIT = 2'b10
  } main_state_t;

  function automatic cyc_t mk(logic last, logic wr, logic [11:0] a,
                              logic [DATA_W-1:0] d);
    cyc_t c;
    c.last = last;
    c.wr = wr;
    c.addr = ADDR_W'(a);
    c.data = d;
    return c;
  endfunction : mk

  function automatic logic op_legal(prot_host_pkg::op_t op,
                                    prot_host_pkg::set_t s);
    logic ok;
    ok = 1'b0;
    case (op)
      prot_host_pkg::OP_ENTER_LOCK, prot_host_pkg::OP_ENTER_PW,
      prot_host_pkg::OP_ENTER_NVP: ok = (s == prot_host_pkg::SET_NONE);
      prot_host_pkg::OP_EXIT: ok = (s != prot_host_pkg::SET_NONE);
      prot_host_pkg::OP_CLEAR_ALL, prot_host_pkg::OP_SET_NVP,
      prot_host_pkg::OP_READ_NVP: ok = (s == prot_host_pkg::SET_NVP);
      prot_host_pkg::OP_PROG_PW, prot_host_pkg::OP_READ_PW,
      prot_host_pkg::OP_UNLOCK: ok = (s == prot_host_pkg::SET_PW);
      prot_host_pkg::OP_PROG_LOCK,
      prot_host_pkg::OP_READ_LOCK: ok = (s == prot_host_pkg::SET_LOCK);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : op_legal

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  main_state_t state_r;
  prot_host_pkg::op_t op_r;
  prot_host_pkg::set_t set_r;
  logic [2:0] step_r;
  logic [ADDR_W-1:0] cmd_addr_r;
  logic [DATA_W-1:0] cmd_data_r;
  logic [DATA_W-1:0] pw_r [4];
  logic [DATA_W-1:0] rdata_r;
  logic done_r;
  logic refused_r;
  logic prot_r;
  logic [10:0] gap_cnt_r;
  logic busy;
  logic acc;
  logic cmd_wr;
  logic cmd_ok;
  logic finish;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  cyc_t cur;
  prot_host_pkg::op_t new_op;

  assign busy = (state_r != M_IDLE);
  assign acc = psel && penable && pready;
  assign cmd_wr = acc && pwrite && (paddr == prot_host_pkg::REG_CMD);
  assign new_op = prot_host_pkg::op_t'(pwdata[3:0]);
  assign cmd_ok = !busy && op_legal(new_op, set_r);
  assign finish = (state_r == M_WAIT) && cyc_done && cur.last;

  // ----------------------------------------------------------------
  // apb slave: one wait state, unmapped -> pslverr
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        case (paddr)
          prot_host_pkg::REG_CMD: prdata <= 32'({op_r});
          prot_host_pkg::REG_ADDR: prdata <= 32'(cmd_addr_r);
          prot_host_pkg::REG_DATA: prdata <= 32'(cmd_data_r);
          prot_host_pkg::REG_STATUS: begin
            prdata[prot_host_pkg::ST_BUSY] <= busy;
            prdata[prot_host_pkg::ST_DONE] <= done_r;
            prdata[prot_host_pkg::ST_REFUSED] <= refused_r;
            prdata[prot_host_pkg::ST_SET_LSB +: 2] <= set_r;
            prdata[prot_host_pkg::ST_PROT] <= prot_r;
          end
          prot_host_pkg::REG_RDATA: prdata <= 32'(rdata_r);
          default: begin
            if (paddr >= prot_host_pkg::REG_PW0 &&
                paddr <= prot_host_pkg::REG_PW3 && paddr[1:0] == 2'b00) begin
              prdata <= 32'(pw_r[paddr[3:2] - 2'b01]);
            end else begin
              pslverr <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_addr_r <= '0;
      cmd_data_r <= prot_host_pkg::WORD_RST;
      for (int i = 0; i < 4; i++) begin
        pw_r[i] <= prot_host_pkg::PW_RST;
      end
    end else if (acc && pwrite) begin
      if (paddr == prot_host_pkg::REG_ADDR) begin
        cmd_addr_r <= pwdata[ADDR_W-1:0];
      end
      if (paddr == prot_host_pkg::REG_DATA) begin
        cmd_data_r <= pwdata[DATA_W-1:0];
      end
      if (paddr >= prot_host_pkg::REG_PW0 &&
          paddr <= prot_host_pkg::REG_PW3 && paddr[1:0] == 2'b00) begin
        pw_r[paddr[3:2] - 2'b01] <= pwdata[DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // command sequence table
  // ----------------------------------------------------------------
  always_comb begin
    cur = mk(1'b1, 1'b1, prot_host_pkg::ADR_00, '0);
    case (op_r)
      prot_host_pkg::OP_ENTER_LOCK, prot_host_pkg::OP_ENTER_PW,
      prot_host_pkg::OP_ENTER_NVP: begin
        case (step_r)
          3'd0: cur = mk(1'b0, 1'b1, prot_host_pkg::ADR_555,
                         DATA_W'(prot_host_pkg::D_AA));
          3'd1: cur = mk(1'b0, 1'b1, prot_host_pkg::ADR_2AA,
                         DATA_W'(prot_host_pkg::D_55));
          default: begin
            cur = mk(1'b1, 1'b1, prot_host_pkg::ADR_555,
                     DATA_W'(prot_host_pkg::D_40));
            if (op_r == prot_host_pkg::OP_ENTER_PW) begin
              cur.data = DATA_W'(prot_host_pkg::D_60);
            end else if (op_r == prot_host_pkg::OP_ENTER_NVP) begin
              cur.data = DATA_W'(prot_host_pkg::D_C0);
            end
          end
        endcase
      end
      prot_host_pkg::OP_EXIT: begin
        cur = mk(step_r != 3'd0, 1'b1, prot_host_pkg::ADR_00,
                 DATA_W'((step_r == 3'd0) ? prot_host_pkg::D_90
                                          : prot_host_pkg::D_00));
      end
      prot_host_pkg::OP_CLEAR_ALL: begin
        cur = mk(step_r != 3'd0, 1'b1, prot_host_pkg::ADR_00,
                 DATA_W'((step_r == 3'd0) ? prot_host_pkg::D_80
                                          : prot_host_pkg::D_30));
      end
      prot_host_pkg::OP_SET_NVP, prot_host_pkg::OP_PROG_PW,
      prot_host_pkg::OP_PROG_LOCK: begin
        cur = mk(1'b0, 1'b1, prot_host_pkg::ADR_00,
                 DATA_W'(prot_host_pkg::D_A0));
        if (step_r != 3'd0) begin
          cur.last = 1'b1;
          cur.data = cmd_data_r;
          if (op_r == prot_host_pkg::OP_SET_NVP) begin
            cur.addr = cmd_addr_r;
            cur.data = DATA_W'(prot_host_pkg::D_00);
          end else if (op_r == prot_host_pkg::OP_PROG_PW) begin
            cur.addr = ADDR_W'(cmd_addr_r[1:0]);
          end
        end
      end
      prot_host_pkg::OP_UNLOCK: begin
        case (step_r)
          3'd0: cur = mk(1'b0, 1'b1, prot_host_pkg::ADR_00,
                         DATA_W'(prot_host_pkg::D_25));
          3'd1: cur = mk(1'b0, 1'b1, prot_host_pkg::ADR_00,
                         DATA_W'(prot_host_pkg::D_03));
          3'd6: cur = mk(1'b1, 1'b1, prot_host_pkg::ADR_00,
                         DATA_W'(prot_host_pkg::D_29));
          default: begin
            cur = mk(1'b0, 1'b1, 12'(step_r - 3'd2),
                     pw_r[2'(step_r - 3'd2)]);
          end
        endcase
      end
      prot_host_pkg::OP_READ_PW: begin
        cur = mk(1'b1, 1'b0, 12'(cmd_addr_r[1:0]), '0);
      end
      prot_host_pkg::OP_READ_NVP: begin
        cur = mk(1'b1, 1'b0, prot_host_pkg::ADR_00, '0);
        cur.addr = cmd_addr_r;
      end
      default: begin
        cur = mk(1'b1, 1'b0, prot_host_pkg::ADR_00, '0);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= M_IDLE;
      op_r <= prot_host_pkg::OP_ENTER_LOCK;
      step_r <= 3'd0;
    end else begin
      case (state_r)
        M_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            op_r <= new_op;
            step_r <= 3'd0;
            state_r <= (new_op == prot_host_pkg::OP_UNLOCK) ? M_GAP
                                                             : M_ISSUE;
          end
        end
        M_GAP: begin
          // too-early unlock would be dropped silently, so hold it
          if (gap_cnt_r == 11'd0) begin
            state_r <= M_ISSUE;
          end
        end
        M_ISSUE: state_r <= M_WAIT;
        M_WAIT: begin
          if (cyc_done) begin
            step_r <= step_r + 3'd1;
            state_r <= cur.last ? M_IDLE : M_ISSUE;
          end
        end
        default: state_r <= M_IDLE;
      endcase
    end
  end

  // set tracking, results, flags; a new command clears done unless finish sets it in the same cycle, and sets refused if it is refused or clears it if accepted
  always_ff @(posedge clk) begin
    if (srst) begin
      set_r <= prot_host_pkg::SET_NONE;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      prot_r <= 1'b0;
      rdata_r <= prot_host_pkg::WORD_RST;
    end else begin
      if (cmd_wr) begin
        done_r <= 1'b0;
        refused_r <= !cmd_ok;
      end
      if (finish) begin
        done_r <= 1'b1;
        case (op_r)
          prot_host_pkg::OP_ENTER_LOCK: set_r <= prot_host_pkg::SET_LOCK;
          prot_host_pkg::OP_ENTER_PW: set_r <= prot_host_pkg::SET_PW;
          prot_host_pkg::OP_ENTER_NVP: set_r <= prot_host_pkg::SET_NVP;
          prot_host_pkg::OP_EXIT: set_r <= prot_host_pkg::SET_NONE;
          default: set_r <= set_r;
        endcase
        if (!cur.wr) begin
          rdata_r <= cyc_rdata;
        end
        if (op_r == prot_host_pkg::OP_READ_NVP) begin
          prot_r <= !cyc_rdata[0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gap_cnt_r <= 11'd0;
    end else if (finish && op_r == prot_host_pkg::OP_UNLOCK) begin
      gap_cnt_r <= 11'(prot_host_pkg::GAP_CYC);
    end else if (gap_cnt_r != 11'd0) begin
      gap_cnt_r <= gap_cnt_r - 11'd1;
    end
  end

  flash_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .clk(clk),
    .srst(srst),
    .start(state_r == M_ISSUE),
    .wr(cur.wr),
    .addr(cur.addr),
    .wdata(cur.data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_issue(int st);
    state_r == M_ISSUE && step_r == 3'(st);
  endsequence

  property p_enter_third;
    @(posedge clk) disable iff (srst)
      s_issue(2) and (op_r == prot_host_pkg::OP_ENTER_NVP) |->
        cur.addr == ADDR_W'(12'h555) && cur.data == DATA_W'(8'hC0);
  endproperty
  a_enter_third: assert property (p_enter_third)
    else $error("nonvolatile set entry code wrong");

  property p_enter_first;
    @(posedge clk) disable iff (srst)
      s_issue(0) and (op_r == prot_host_pkg::OP_ENTER_LOCK) |->
        ##1 (fl_addr == ADDR_W'(12'h555) && dq_o == DATA_W'(8'hAA));
  endproperty
  a_enter_first: assert property (p_enter_first)
    else $error("first unlock cycle not AA at 555");

  property p_exit_tail;
    @(posedge clk) disable iff (srst)
      s_issue(1) and (op_r == prot_host_pkg::OP_EXIT) |->
        cur.last && cur.data == '0;
  endproperty
  a_exit_tail: assert property (p_exit_tail)
    else $error("exit sequence second cycle wrong");

  property p_clear_tail;
    @(posedge clk) disable iff (srst)
      s_issue(1) and (op_r == prot_host_pkg::OP_CLEAR_ALL) |->
        cur.addr == '0 && cur.data == DATA_W'(8'h30);
  endproperty
  a_clear_tail: assert property (p_clear_tail)
    else $error("clear-all second cycle wrong");

  property p_unlock_end;
    @(posedge clk) disable iff (srst)
      s_issue(6) and (op_r == prot_host_pkg::OP_UNLOCK) |->
        cur.last && cur.data == DATA_W'(8'h29);
  endproperty
  a_unlock_end: assert property (p_unlock_end)
    else $error("unlock not closed by 29");

  property p_unlock_gap;
    @(posedge clk) disable iff (srst)
      s_issue(0) and (op_r == prot_host_pkg::OP_UNLOCK) |->
        gap_cnt_r == 11'd0;
  endproperty
  a_unlock_gap: assert property (p_unlock_gap)
    else $error("unlock issued inside spacing");

  property p_refuse;
    @(posedge clk) disable iff (srst)
      cmd_wr && !busy && set_r == prot_host_pkg::SET_NONE &&
        new_op != prot_host_pkg::OP_ENTER_LOCK &&
        new_op != prot_host_pkg::OP_ENTER_PW &&
        new_op != prot_host_pkg::OP_ENTER_NVP |->
        ##1 (refused_r && state_r == M_IDLE);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("command outside a set not refused");

  property p_prot_flag;
    @(posedge clk) disable iff (srst)
      finish && op_r == prot_host_pkg::OP_READ_NVP |->
        ##1 (prot_r == !$past(cyc_rdata[0]) && done_r);
  endproperty
  a_prot_flag: assert property (p_prot_flag)
    else $error("protection flag decoded wrong");

  property p_apb_once;
    @(posedge clk) disable iff (srst)
      pready |=> !pready;
  endproperty
  a_apb_once: assert property (p_apb_once)
    else $error("pready held two cycles");

endmodule : prot_host

//--- pkg/prot_host_pkg.sv
package prot_host_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, apb)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PW0 = 8'h14;
  localparam logic [7:0] REG_PW3 = 8'h20;

  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SET_LSB = 4;
  localparam int ST_PROT = 6;

  localparam logic [15:0] PW_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // commands, command sets
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ENTER_LOCK = 4'h0, OP_ENTER_PW = 4'h1, OP_ENTER_NVP = 4'h2,
    OP_EXIT = 4'h3, OP_CLEAR_ALL = 4'h4, OP_SET_NVP = 4'h5,
    OP_PROG_PW = 4'h6, OP_READ_PW = 4'h7, OP_UNLOCK = 4'h8,
    OP_READ_NVP = 4'h9, OP_PROG_LOCK = 4'hA, OP_READ_LOCK = 4'hB
  } op_t;

  typedef enum logic [1:0] {
    SET_NONE = 2'h0, SET_LOCK = 2'h1, SET_PW = 2'h2, SET_NVP = 2'h3
  } set_t;

  // ----------------------------------------------------------------
  // bus cycle addresses and data codes
  // ----------------------------------------------------------------
  localparam logic [11:0] ADR_555 = 12'h555;
  localparam logic [11:0] ADR_2AA = 12'h2AA;
  localparam logic [11:0] ADR_00 = 12'h000;
  localparam logic [7:0] D_AA = 8'hAA;
  localparam logic [7:0] D_55 = 8'h55;
  localparam logic [7:0] D_40 = 8'h40;
  localparam logic [7:0] D_60 = 8'h60;
  localparam logic [7:0] D_C0 = 8'hC0;
  localparam logic [7:0] D_90 = 8'h90;
  localparam logic [7:0] D_00 = 8'h00;
  localparam logic [7:0] D_80 = 8'h80;
  localparam logic [7:0] D_30 = 8'h30;
  localparam logic [7:0] D_A0 = 8'hA0;
  localparam logic [7:0] D_25 = 8'h25;
  localparam logic [7:0] D_03 = 8'h03;
  localparam logic [7:0] D_29 = 8'h29;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_WP_NS = 50;
  localparam int T_WH_NS = 30;
  localparam int T_ACC_NS = 120;
  localparam int T_UNLOCK_GAP_NS = 6000;

  function automatic int ns_to_cyc(int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int WP_CYC = ns_to_cyc(T_WP_NS);
  localparam int WH_CYC = ns_to_cyc(T_WH_NS);
  localparam int ACC_CYC = ns_to_cyc(T_ACC_NS);
  localparam int GAP_CYC = ns_to_cyc(T_UNLOCK_GAP_NS);

endpackage : prot_host_pkg

//--- rtl/flash_cycle.sv
module flash_cycle #(
  parameter int ADDR_W = 27,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);

  // ----------------------------------------------------------------
  // one asynchronous bus cycle, read or write
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_STROBE = 2'b01, C_RECOVER = 2'b11
  } cyc_state_t;

  cyc_state_t state_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic [DATA_W-1:0] dq_meta_r;
  logic [DATA_W-1:0] dq_sync_r;

  // pins are asynchronous to clk
  always_ff @(posedge clk) begin
    dq_meta_r <= dq_i;
    dq_sync_r <= dq_meta_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= C_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      fl_addr <= '0;
      dq_o <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_r)
        C_IDLE: begin
          if (start) begin
            fl_addr <= addr;
            dq_o <= wdata;
            dq_oe <= wr;
            ce_n <= 1'b0;
            we_n <= !wr;
            oe_n <= wr;
            wr_r <= wr;
            // reads wait two more cycles for the synchroniser
            cnt_r <= wr ? 8'(prot_host_pkg::WP_CYC - 1)
                        : 8'(prot_host_pkg::ACC_CYC + 1);
            state_r <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (cnt_r == 8'h00) begin
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_r) begin
              rdata <= dq_sync_r;
            end
            cnt_r <= 8'(prot_host_pkg::WH_CYC - 1);
            state_r <= C_RECOVER;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        C_RECOVER: begin
          // data held through recovery for write hold time
          if (cnt_r == 8'h00) begin
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r <= C_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_we_drives;
    @(posedge clk) disable iff (srst)
      !we_n |-> (dq_oe && !ce_n && oe_n);
  endproperty
  a_we_drives: assert property (p_we_drives)
    else $error("write strobe without data drive");

  property p_no_contention;
    @(posedge clk) disable iff (srst)
      !oe_n |-> !dq_oe;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("output enable while driving data");

endmodule : flash_cycle

//--- tb/flash_model.sv
module flash_model (
  input wire logic [26:0] fl_addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------
  // device side, four blocks only
  // ----------------------------
  logic [3:0] nvp_r = 4'hF;
  logic [3:0] vp_r = 4'hF;
  logic [15:0] pw_m [4] = '{default: 16'hFFFF};
  logic lock_r = 1'b1;
  logic [1:0] set_r = 2'h0;
  logic [7:0] h1 = 8'h0, h2 = 8'h0, d;
  logic [1:0] b;
  assign d = dq_o[7:0];
  assign b = fl_addr[17:16];
  // word latched at the rising write strobe, data still standing
  always @(posedge we_n) begin
    if (h2 == 8'hAA && h1 == 8'h55 && set_r == 2'h0)
      set_r <= d == 8'h40 ? 2'h1 : d == 8'h60 ? 2'h2 : 2'h3;
    else if (h1 == 8'h90 && d == 8'h00)
      set_r <= 2'h0;
    else if (set_r == 2'h3 && lock_r && h1 == 8'h80 && d == 8'h30)
      nvp_r <= 4'hF;
    else if (set_r == 2'h3 && lock_r && h1 == 8'hA0 && d == 8'h00)
      nvp_r[b] <= 1'b0;
    else if (set_r == 2'h2 && h1 == 8'hA0)
      pw_m[fl_addr[1:0]] <= dq_o;
    h2 <= h1;
    h1 <= d;
  end
  // released bus changes pattern so a stale word never looks valid
  always @(oe_n or fl_addr or nvp_r or set_r) begin
    if (oe_n)
      dq_i = ~dq_i;
    else if (set_r == 2'h2)
      dq_i = pw_m[fl_addr[1:0]];
    else if (set_r == 2'h0)
      dq_i = {15'h0, ~nvp_r[b] | ~vp_r[b]};
    else
      dq_i = {15'h0, nvp_r[b]};
  end
endmodule : flash_model

//--- tb/prot_host_tb.sv
module prot_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------
  // stimulus and checks
  // ----------------------------
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, dq_oe, ce_n, we_n, oe_n, perr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, s, q;
  logic [26:0] fl_addr;
  logic [15:0] dq_o, dq_i;
  int err_total = 0;
  int cmp_count = 0;
  prot_host i_prot_host (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  flash_model i_flash_model (.fl_addr(fl_addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // no bound here: the watchdog cuts a stuck busy flag short
  task automatic run(input logic [3:0] op, input logic [31:0] ad);
    apb(1'b1, prot_host_pkg::REG_ADDR, ad);
    apb(1'b1, prot_host_pkg::REG_CMD, {28'h0, op});
    do apb(1'b0, prot_host_pkg::REG_STATUS, 32'h0); while (q[0] === 1'b1);
    s = q;
  endtask : run
  task automatic t_sets;
    for (int i = 0; i < 3; i++) begin
      run(4'(i), 32'h0);
      chk(s & 32'h76, 32'h2 | (32'(i + 1) << 4));
      run(prot_host_pkg::OP_EXIT, 32'h0);
      chk(s & 32'h76, 32'h2);
    end
    $display("t_sets done");
  endtask : t_sets
  task automatic t_nvp;
    run(prot_host_pkg::OP_ENTER_NVP, 32'h0);
    run(prot_host_pkg::OP_ENTER_LOCK, 32'h0);
    chk(s & 32'h34, 32'h34);
    run(prot_host_pkg::OP_READ_NVP, 32'h0001_0000);
    chk(s & 32'h42, 32'h2);
    run(prot_host_pkg::OP_SET_NVP, 32'h0001_0000);
    run(prot_host_pkg::OP_READ_NVP, 32'h0001_FFFF);
    chk(s & 32'h42, 32'h42);
    apb(1'b0, prot_host_pkg::REG_RDATA, 32'h0);
    chk(q & 32'h1, 32'h0);
    run(prot_host_pkg::OP_READ_NVP, 32'h0002_0000);
    chk(s & 32'h42, 32'h2);
    run(prot_host_pkg::OP_CLEAR_ALL, 32'h0);
    run(prot_host_pkg::OP_READ_NVP, 32'h0001_0000);
    chk(s & 32'h42, 32'h2);
    run(prot_host_pkg::OP_EXIT, 32'h0);
    $display("t_nvp done");
  endtask : t_nvp
  // password set, unlock spacing, then a command refused outside a set
  task automatic t_pw;
    time t0;
    run(prot_host_pkg::OP_ENTER_PW, 32'h0);
    apb(1'b1, prot_host_pkg::REG_PW3, 32'h0000_5A3C);
    apb(1'b0, prot_host_pkg::REG_PW3, 32'h0);
    chk(q, 32'h0000_5A3C);
    apb(1'b1, prot_host_pkg::REG_DATA, 32'h0000_1234);
    run(prot_host_pkg::OP_PROG_PW, 32'h0000_0002);
    run(prot_host_pkg::OP_READ_PW, 32'h0000_0002);
    apb(1'b0, prot_host_pkg::REG_RDATA, 32'h0);
    chk(q, 32'h0000_1234);
    run(prot_host_pkg::OP_UNLOCK, 32'h0);
    chk(s & 32'h36, 32'h22);
    t0 = $time;
    run(prot_host_pkg::OP_UNLOCK, 32'h0);
    chk(32'($time - t0 >= prot_host_pkg::T_UNLOCK_GAP_NS), 32'h1);
    run(prot_host_pkg::OP_EXIT, 32'h0);
    run(prot_host_pkg::OP_EXIT, 32'h0);
    chk(s & 32'h34, 32'h4);
    $display("t_pw done");
  endtask : t_pw
  task automatic t_bus;
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(q, 32'h0);
    $display("t_bus done");
  endtask : t_bus
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_sets();
    t_nvp();
    t_pw();
    t_bus();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : prot_host_tb
